// File: include/scir_pkg.sv
// Purpose: shared constants and types of the serial configuration bank
// Assumes: 16-bit frame header (read flag + 15-bit address), byte data
// Notes: byte addresses are those seen by the serial host
package scir_pkg;

	// frame layout
	localparam int ADDR_W = 15;
	localparam int CNT_W = 5;
	localparam logic [4:0] HDR_LAST = 5'h0F;
	localparam logic [4:0] DATA_FIRST = 5'h10;
	localparam logic [4:0] DATA_LAST = 5'h17;
	localparam logic [4:0] CNT_STEP = 5'h01;
	localparam int HDR_RW_BIT = 14;

	// register byte addresses
	localparam logic [14:0] ADDR_GEN_CFG = 15'h0000;
	localparam logic [14:0] ADDR_DEV_CFG = 15'h0002;
	localparam logic [14:0] ADDR_DEV_CLASS = 15'h0003;
	localparam logic [14:0] ADDR_ID_LO = 15'h0004;
	localparam logic [14:0] ADDR_ID_HI = 15'h0005;
	localparam logic [14:0] ADDR_STREAM_CTRL = 15'h0010;
	localparam logic [14:0] ADDR_COEF_LO = 15'h0459;
	localparam logic [14:0] ADDR_COEF_HI = 15'h045A;
	localparam logic [14:0] ADDR_STEP = 15'h0001;

	// field positions
	localparam int GEN_SOFT_RESET_BIT = 7;
	localparam int GEN_ASCEND_BIT = 5;
	localparam int GEN_OUT_PIN_BIT = 4;
	localparam int STREAM_FREEZE_BIT = 0;
	localparam int MODE_MSB = 1;

	// writable bits and fixed ones of the general configuration
	localparam logic [7:0] GEN_RW_MASK = 8'h6F;
	localparam logic [7:0] GEN_FIXED_ONES = 8'h10;

	// values after reset
	localparam logic [7:0] GEN_CFG_RESET = 8'h30;
	localparam logic [7:0] DEV_CFG_RESET = 8'h00;
	localparam logic [3:0] CLASS_UPPER_RESET = 4'h0;
	localparam logic [7:0] STREAM_CTRL_RESET = 8'h00;
	localparam logic [15:0] COEF_RESET = 16'h0000;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;

	// operating state
	typedef enum logic [1:0] {
		SCIR_NORMAL = 2'b00,
		SCIR_RSV_1 = 2'b01,
		SCIR_RSV_2 = 2'b10,
		SCIR_POWER_DOWN = 2'b11
	} scir_mode_t;

	// timing
	localparam int CLK_PERIOD_NS = 50;
	localparam int SOFT_RESET_NS = 750;
	localparam int SYNC_CYCLES = 4;
	localparam int SOFT_RESET_CYCLES =
		(SOFT_RESET_NS / CLK_PERIOD_NS) - SYNC_CYCLES;

endpackage

// File: hw/scir_sync.sv
// Purpose: two-flop level synchroniser into the destination clock
// Assumes: every bit is a level or quasi-static word qualified elsewhere
// Notes: no reset; the first stage is read by the second stage only
`timescale 1ns/1ps
module scir_sync #(
	parameter int WIDTH = 1
) (
	// destination clock
	input wire logic clk,
	// levels
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);

	logic [WIDTH-1:0] meta;

	always_ff @(posedge clk)
	begin
		meta <= d;
		q <= meta;
	end

endmodule // scir_sync

// File: hw/scir_pulse_timer.sv
// Purpose: holds busy for a fixed number of system clock cycles
// Assumes: start is a one-cycle pulse on clk
// Notes: a start while busy restarts the full interval
`timescale 1ns/1ps
module scir_pulse_timer #(
	parameter int CYCLES = 11
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// control
	input wire logic start,
	output logic busy
);

	localparam int W = $clog2(CYCLES + 1);

	logic [W-1:0] count;

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			count <= '0;
			busy <= 1'b0;
		end
		else if (start)
		begin
			count <= W'(CYCLES - 1);
			busy <= 1'b1;
		end
		else if (count != '0)
			count <= count - 1'b1;
		else
			busy <= 1'b0;
	end

endmodule // scir_pulse_timer

// File: hw/scir_regs.sv
// Purpose: serial configuration and identity register bank
// Assumes: host frames are 16 header bits then data bytes, sampled on
//   rising serial_clk, with serial_clk idle while serial_sel_n is high
// Notes: registers live on serial_clk so reads need no wait states;
//   the system side sees them through synchronisers
`timescale 1ns/1ps
module scir_regs #(
	// arbitrary class code, not any real part's
	parameter logic [3:0] DEVICE_CLASS = 4'h9,
	// arbitrary identification, not any real part's
	parameter logic [15:0] DEVICE_ID = 16'hA5C3
) (
	// system clock and reset
	input wire logic clk,
	input wire logic reset,
	// serial link
	input wire logic serial_clk,
	input wire logic serial_sel_n,
	input wire logic serial_in,
	output logic serial_output_pin,
	output logic serial_output_oe_n,
	// device controls
	output scir_pkg::scir_mode_t operating_mode,
	output logic chip_reset
);

	import scir_pkg::*;

	// system side reset copy, glitch free, clears the link side
	logic rst_q;

	// link side reset handshake
	logic lrst_meta;
	logic lrst_done;
	logic hw_ack;
	logic hw_load;

	// frame tracking
	logic [CNT_W-1:0] bit_cnt;
	logic [CNT_W-1:0] next_bit_cnt;
	logic [ADDR_W-1:0] hdr;
	logic [ADDR_W-1:0] hdr_addr;
	logic [ADDR_W-1:0] cur_addr;
	logic [ADDR_W-1:0] step_addr;
	logic rd_mode;
	logic hdr_done;
	logic in_data;
	logic byte_done;
	logic commit;
	logic drive_en;

	// data shifters
	logic [6:0] wr_shift;
	logic [7:0] wdata;
	logic [7:0] rd_shift;

	// register storage
	logic [7:0] gen_cfg;
	logic [7:0] dev_cfg;
	logic [3:0] class_upper;
	logic [7:0] stream_ctrl;
	logic [15:0] coef;

	// register controls
	logic addr_freeze;
	logic addr_ascend;
	logic wr_gen;
	logic wr_dev;
	logic wr_class;
	logic wr_stream;
	logic wr_coef_lo;
	logic wr_coef_hi;
	logic soft_reset_wr;
	logic load_defaults;
	logic sr_tog;

	// system side
	logic [3:0] sys_sync;
	logic sys_ack;
	logic sys_tog;
	logic tog_seen;
	logic sr_start;
	logic sr_busy;

	// read image of one byte address
	function automatic logic [7:0] scir_read(
		input logic [ADDR_W-1:0] addr,
		input logic [7:0] gen,
		input logic [7:0] dev,
		input logic [3:0] cls_hi,
		input logic [7:0] stream,
		input logic [15:0] cf
	);
		logic [7:0] val;
		val = UNMAPPED_READ;
		case (addr)
			ADDR_GEN_CFG: val = gen | GEN_FIXED_ONES;
			ADDR_DEV_CFG: val = dev;
			ADDR_DEV_CLASS: val = {cls_hi, DEVICE_CLASS};
			ADDR_ID_LO: val = DEVICE_ID[7:0];
			ADDR_ID_HI: val = DEVICE_ID[15:8];
			ADDR_STREAM_CTRL: val = stream;
			ADDR_COEF_LO: val = cf[7:0];
			ADDR_COEF_HI: val = cf[15:8];
			default: val = UNMAPPED_READ;
		endcase
		return val;
	endfunction

	always_ff @(posedge clk)
	begin
		rst_q <= reset;
	end

	// reset synchroniser on the link clock; defaults load once on the
	// third link edge after a system reset, before any data bit
	always_ff @(posedge serial_clk or posedge rst_q)
	begin
		if (rst_q)
		begin
			lrst_meta <= 1'b0;
			lrst_done <= 1'b0;
		end
		else
		begin
			lrst_meta <= 1'b1;
			lrst_done <= lrst_meta;
		end
	end

	assign hw_load = lrst_done & ~hw_ack;

	always_ff @(posedge serial_clk or posedge rst_q)
	begin
		if (rst_q)
			hw_ack <= 1'b0;
		else if (hw_load)
			hw_ack <= 1'b1;
	end

	// bit counter ends with the frame, since the link clock stops there
	assign next_bit_cnt = (bit_cnt == DATA_LAST) ? DATA_FIRST
		: bit_cnt + CNT_STEP;

	always_ff @(posedge serial_clk or posedge serial_sel_n)
	begin
		if (serial_sel_n)
			bit_cnt <= '0;
		else
			bit_cnt <= next_bit_cnt;
	end

	assign hdr_done = (bit_cnt == HDR_LAST);
	assign in_data = (bit_cnt >= DATA_FIRST);
	assign byte_done = (bit_cnt == DATA_LAST);
	assign hdr_addr = {hdr[ADDR_W-2:0], serial_in};
	assign wdata = {wr_shift, serial_in};
	assign commit = byte_done & ~rd_mode;

	// streaming address: freeze wins over direction
	assign addr_freeze = stream_ctrl[STREAM_FREEZE_BIT];
	assign addr_ascend = gen_cfg[GEN_ASCEND_BIT];
	assign step_addr = addr_freeze ? cur_addr
		: addr_ascend ? cur_addr + ADDR_STEP
		: cur_addr - ADDR_STEP;

	always_ff @(posedge serial_clk)
	begin
		if (!in_data)
			hdr <= hdr_addr;
	end

	always_ff @(posedge serial_clk)
	begin
		if (hdr_done)
		begin
			rd_mode <= hdr[HDR_RW_BIT];
			cur_addr <= hdr_addr;
		end
		else if (byte_done)
			cur_addr <= step_addr;
	end

	always_ff @(posedge serial_clk)
	begin
		if (in_data)
			wr_shift <= wdata[6:0];
	end

	// next byte is fetched on the edge that finishes the current one
	always_ff @(posedge serial_clk)
	begin
		if (hdr_done)
			rd_shift <= scir_read(hdr_addr, gen_cfg, dev_cfg,
				class_upper, stream_ctrl, coef);
		else if (byte_done)
			rd_shift <= scir_read(step_addr, gen_cfg, dev_cfg,
				class_upper, stream_ctrl, coef);
		else
			rd_shift <= {rd_shift[6:0], 1'b0};
	end

	// read data leaves only on the dedicated pin; serial_in never turns
	// around, so there is no three-wire option
	assign drive_en = in_data & rd_mode;

	always_ff @(negedge serial_clk or posedge serial_sel_n)
	begin
		if (serial_sel_n)
		begin
			serial_output_pin <= 1'b0;
			serial_output_oe_n <= 1'b1;
		end
		else
		begin
			serial_output_pin <= rd_shift[7] & drive_en;
			serial_output_oe_n <= ~drive_en;
		end
	end

	// write decode
	assign wr_gen = commit & (cur_addr == ADDR_GEN_CFG);
	assign wr_dev = commit & (cur_addr == ADDR_DEV_CFG);
	assign wr_class = commit & (cur_addr == ADDR_DEV_CLASS);
	assign wr_stream = commit & (cur_addr == ADDR_STREAM_CTRL);
	assign wr_coef_lo = commit & (cur_addr == ADDR_COEF_LO);
	assign wr_coef_hi = commit & (cur_addr == ADDR_COEF_HI);
	assign soft_reset_wr = wr_gen & wdata[GEN_SOFT_RESET_BIT];
	assign load_defaults = hw_load | soft_reset_wr;

	// soft reset takes effect on the very edge that completes the byte;
	// the reset bit is never stored, so it reads back zero
	always_ff @(posedge serial_clk)
	begin
		if (load_defaults)
			gen_cfg <= GEN_CFG_RESET & GEN_RW_MASK;
		else if (wr_gen)
			gen_cfg <= wdata & GEN_RW_MASK;
	end

	always_ff @(posedge serial_clk)
	begin
		if (load_defaults)
			dev_cfg <= DEV_CFG_RESET;
		else if (wr_dev)
			dev_cfg <= wdata;
	end

	// the class code nibble has no storage, so writes cannot reach it
	always_ff @(posedge serial_clk)
	begin
		if (load_defaults)
			class_upper <= CLASS_UPPER_RESET;
		else if (wr_class)
			class_upper <= wdata[7:4];
	end

	always_ff @(posedge serial_clk)
	begin
		if (load_defaults)
			stream_ctrl <= STREAM_CTRL_RESET;
		else if (wr_stream)
			stream_ctrl <= wdata;
	end

	always_ff @(posedge serial_clk)
	begin
		if (load_defaults)
			coef <= COEF_RESET;
		else
		begin
			if (wr_coef_lo)
				coef[7:0] <= wdata;
			if (wr_coef_hi)
				coef[15:8] <= wdata;
		end
	end

	// each soft reset flips this; the system side turns the flip into
	// a reset pulse for the rest of the chip
	always_ff @(posedge serial_clk)
	begin
		if (hw_load)
			sr_tog <= 1'b0;
		else if (soft_reset_wr)
			sr_tog <= ~sr_tog;
	end

	// crossing to the system clock; mode is quasi-static and is only
	// trusted once the handshake bit shows the link side initialised
	scir_sync #(
		.WIDTH(4)
	) u_to_sys (
		.clk(clk),
		.d({hw_ack, sr_tog, dev_cfg[MODE_MSB:0]}),
		.q(sys_sync)
	);

	assign sys_ack = sys_sync[3];
	assign sys_tog = sys_sync[2];
	assign sr_start = sys_ack & (sys_tog != tog_seen) & ~reset;

	always_ff @(posedge clk)
	begin
		if (reset)
			tog_seen <= 1'b0;
		else
			tog_seen <= sys_ack ? sys_tog : 1'b0;
	end

	// interval is trimmed by the crossing latency so the chip reset
	// ends inside the window the host must stay quiet for
	scir_pulse_timer #(
		.CYCLES(SOFT_RESET_CYCLES)
	) u_sr_timer (
		.clk(clk),
		.reset(reset),
		.start(sr_start),
		.busy(sr_busy)
	);

	always_ff @(posedge clk)
	begin
		if (reset)
			chip_reset <= 1'b1;
		else
			chip_reset <= sr_busy;
	end

	// reserved codes pass through unchanged
	always_ff @(posedge clk)
	begin
		if (reset || !sys_ack || sr_busy)
			operating_mode <= SCIR_NORMAL;
		else
			operating_mode <= scir_mode_t'(sys_sync[MODE_MSB:0]);
	end

endmodule // scir_regs

// File: testbench/scir_regs_props.sv
// Purpose: port assertions of the serial configuration bank
// Assumes: serial_clk stands low while serial_sel_n is high
// Notes: bit counter clears when the frame ends
`timescale 1ns/1ps
module scir_regs_props (
	// clocks and reset
	input wire logic clk,
	input wire logic reset,
	input wire logic serial_clk,
	// link
	input wire logic serial_sel_n,
	input wire logic serial_in,
	input wire logic serial_output_pin,
	input wire logic serial_output_oe_n,
	// device controls
	input wire scir_pkg::scir_mode_t operating_mode,
	input wire logic chip_reset
);
	import scir_pkg::*;
	logic [5:0] n_bit;
	logic rd_frame;
	// async clear: no serial_clk edge follows the frame end
	always_ff @(posedge serial_clk or posedge serial_sel_n)
		if (serial_sel_n)
			n_bit <= 6'h00;
		else if (n_bit != 6'h3F)
			n_bit <= n_bit + 6'h01;
	always_ff @(posedge serial_clk)
		if (n_bit == 6'h00)
			rd_frame <= serial_in;

	a_rst_chip_low:
	assert property (@(posedge clk) disable iff (reset)
		$fell(reset) |=> !chip_reset) else $error("reset stuck");
	a_rst_mode_norm:
	assert property (@(posedge clk) disable iff (reset)
		$fell(reset) |-> operating_mode == SCIR_NORMAL)
		else $error("mode not normal");
	a_pulse_len:
	assert property (@(posedge clk) disable iff (reset)
		$rose(chip_reset) |-> chip_reset[*8]) else $error("pulse short");
	a_pulse_end:
	assert property (@(posedge clk) disable iff (reset)
		$rose(chip_reset) |-> ##[1:11] !chip_reset)
		else $error("pulse long");
	a_soft_mode_norm:
	assert property (@(posedge clk) disable iff (reset)
		$fell(chip_reset) |-> operating_mode == SCIR_NORMAL)
		else $error("mode kept");
	a_idle_quiet:
	assert property (@(posedge clk) disable iff (reset)
		serial_sel_n |-> serial_output_oe_n && !serial_output_pin)
		else $error("drives idle");
	a_hdr_quiet:
	assert property (@(negedge serial_clk) disable iff (reset)
		!serial_sel_n && n_bit < 6'h10 |-> serial_output_oe_n)
		else $error("drives in header");
	a_read_drive:
	assert property (@(negedge serial_clk) disable iff (reset)
		!serial_sel_n && n_bit == 6'h10 && rd_frame
		|=> serial_sel_n || !serial_output_oe_n) else $error("no read");
endmodule // scir_regs_props

bind scir_regs scir_regs_props props_u (
	.clk(clk), .reset(reset), .serial_clk(serial_clk),
	.serial_sel_n(serial_sel_n), .serial_in(serial_in),
	.serial_output_pin(serial_output_pin),
	.serial_output_oe_n(serial_output_oe_n),
	.operating_mode(operating_mode), .chip_reset(chip_reset)
);

// File: testbench/scir_host_model.sv
// Purpose: behavioural serial host running framed accesses
// Assumes: device samples on rising serial_clk, shifts on falling
// Notes: clock stands low between frames; released data line toggles
`timescale 1ns/1ps
module scir_host_model (
	// link toward the device
	output logic serial_clk,
	output logic serial_sel_n,
	output logic serial_in,
	input wire logic serial_output_pin,
	input wire logic serial_output_oe_n
);
	// select starts low and rises after time zero; a rise at time zero
	// itself can slip past the device's frame counter clear
	initial
	begin
		serial_clk = 1'b0;
		serial_sel_n = 1'b0;
		serial_in = 1'b0;
		#2 serial_sel_n = 1'b1;
	end
	// header then two bytes, first byte in wd[15:8]
	task automatic frame(input logic rd, input logic [14:0] a,
		input logic [15:0] wd, output logic [15:0] q);
		logic [31:0] sh;
		sh = {rd, a, wd};
		q = 16'h0000;
		#1.3 serial_sel_n = 1'b0;
		for (int i = 31; i >= 0; i--)
		begin
			serial_in = sh[i];
			#3 serial_clk = 1'b1;
			// undriven pin reads unknown so it never matches
			if (i < 16)
				q[i] = serial_output_oe_n ? 1'bx : serial_output_pin;
			#3 serial_clk = 1'b0;
		end
		serial_sel_n = 1'b1;
		serial_in = ~serial_in;
	endtask
endmodule // scir_host_model

// File: testbench/scir_regs_tb.sv
// Purpose: self-checking bench of the serial configuration bank
// Assumes: every host frame carries two data bytes
// Notes: waits are bounded; a lapsed mode wait or chip_reset rise wait ends the run
`timescale 1ns/1ps
module scir_regs_tb;
	import scir_pkg::*;
	localparam logic [3:0] CLS = 4'h9; // arbitrary value
	localparam logic [15:0] ID = 16'hC35A; // arbitrary value
	logic clk, reset, chip_reset;
	wire sclk, sel_n, sin, sout, oe_n;
	scir_mode_t mode;
	int n_mismatch, n_checks, w, h;
	logic [15:0] q;

	scir_regs #(.DEVICE_CLASS(CLS), .DEVICE_ID(ID)) dut_u (
		.clk(clk), .reset(reset), .serial_clk(sclk),
		.serial_sel_n(sel_n), .serial_in(sin),
		.serial_output_pin(sout), .serial_output_oe_n(oe_n),
		.operating_mode(mode), .chip_reset(chip_reset));
	scir_host_model host_u (.serial_clk(sclk), .serial_sel_n(sel_n),
		.serial_in(sin), .serial_output_pin(sout),
		.serial_output_oe_n(oe_n));

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic summarize();
		$display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic lapse();
		n_mismatch++;
		$display("ERROR t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
		summarize();
	endtask
	task automatic wr(input logic [14:0] a, input logic [15:0] d);
		@(negedge clk);
		host_u.frame(1'b0, a, d, q);
	endtask
	task automatic rd(input logic [14:0] a, input logic [15:0] e);
		@(negedge clk);
		host_u.frame(1'b1, a, 16'h0000, q);
		chk(q, e);
	endtask
	task automatic wmode(input scir_mode_t m);
		int i;
		for (i = 0; i < 20 && mode !== m; i++)
			@(negedge clk);
		if (i == 20)
			lapse();
		chk({14'h0000, mode}, {14'h0000, m});
	endtask

	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	initial
	begin
		reset = 1'b1;
		n_mismatch = 0;
		n_checks = 0;
		repeat (3) @(negedge clk);
		reset = 1'b0;
		repeat (2) @(negedge clk);
		wmode(SCIR_NORMAL);
		rd(ADDR_GEN_CFG, 16'h3000);
		rd(ADDR_DEV_CFG, {12'h000, CLS});
		rd(ADDR_ID_LO, {ID[7:0], ID[15:8]});
		wr(ADDR_DEV_CFG, 16'h03F5);
		wmode(SCIR_POWER_DOWN);
		rd(ADDR_DEV_CFG, {8'h03, 4'hF, CLS});
		for (int m = 0; m < 4; m++)
		begin
			wr(ADDR_DEV_CFG, {6'h00, m[1:0], 8'h00});
			wmode(scir_mode_t'(m));
		end
		// descending: second byte lands on an unmapped address
		wr(ADDR_GEN_CFG, 16'h0F00);
		rd(ADDR_GEN_CFG, 16'h1F00);
		rd(ADDR_ID_HI, ID);
		wr(ADDR_STREAM_CTRL, 16'h0100);
		rd(ADDR_ID_LO, {2{ID[7:0]}});
		wr(ADDR_STREAM_CTRL, 16'h0000);
		wr(ADDR_COEF_HI, 16'hBEEF);
		rd(ADDR_COEF_HI, 16'hBEEF);
		wr(ADDR_GEN_CFG, 16'h8000);
		for (w = 0; w < 20 && chip_reset !== 1'b1; w++)
			@(negedge clk);
		if (w == 20)
			lapse();
		for (h = 0; h < 20 && chip_reset === 1'b1; h++)
			@(negedge clk);
		chk(16'(h), 16'(SOFT_RESET_CYCLES));
		chk(16'(w + h <= 15), 16'h0001);
		repeat (SOFT_RESET_NS / CLK_PERIOD_NS) @(negedge clk);
		wmode(SCIR_NORMAL);
		rd(ADDR_GEN_CFG, 16'h3000);
		rd(ADDR_DEV_CFG, {12'h000, CLS});
		rd(ADDR_COEF_LO, 16'h0000);
		wr(ADDR_ID_LO, 16'hFFFF);
		rd(ADDR_ID_LO, {ID[7:0], ID[15:8]});
		summarize();
	end
endmodule // scir_regs_tb
